// file: dv/gde_ahb_mem.sv
// ahb-lite slave memory with wait states and an error address
`timescale 1ns/1ps
module gde_ahb_mem import gde_pkg::*; #(
	parameter logic [31:0] ERR_ADDR = 32'h0000_00FC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        slow,
	output logic [31:0]      hrdata,
	output logic             hready,
	output logic             hresp
);
	logic [31:0] mem [0:63];
	logic        dph;
	logic        dw;
	logic        err;
	logic [5:0]  da;
	logic [1:0]  wcnt;
	logic [31:0] last;

	// read data only in the completing cycle, otherwise it holds the last completed read data
	assign hrdata = (dph && !dw && hready && !hresp) ? mem[da] : ~last;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dph    <= 1'b0;
			dw     <= 1'b0;
			err    <= 1'b0;
			da     <= 6'h00;
			wcnt   <= 2'h0;
			hready <= 1'b1;
			hresp  <= 1'b0;
			last   <= 32'h0000_0000;
		end else begin
			if (dph && hready) begin
				dph   <= 1'b0;
				hresp <= 1'b0;
				if (dw && !err)
					mem[da] <= hwdata;
				last <= ~hrdata;
			end else if (dph) begin
				if (wcnt > 2'h1)
					wcnt <= wcnt - 2'h1;
				else
					hready <= 1'b1;
			end
			if (htrans == GDE_HTRANS_NSEQ && hready) begin
				dph    <= 1'b1;
				dw     <= hwrite;
				da     <= haddr[7:2];
				err    <= (haddr == ERR_ADDR);
				wcnt   <= (haddr == ERR_ADDR) ? 2'h1 : (slow ? 2'h2 : 2'h0);
				hready <= !((haddr == ERR_ADDR) || slow);
				hresp  <= (haddr == ERR_ADDR);
			end
		end
	end
endmodule

// file: dv/gde_top_test.sv
// self-checking bench for the general dma engine
`timescale 1ns/1ps
module gde_top_test import gde_pkg::*; ;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hwrite, hready, hresp;
	logic        irq, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  per_sreq, per_breq, per_clr;
	int          failures, tests_run;

	gde_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp),
		.per_sreq(per_sreq), .per_breq(per_breq), .per_clr(per_clr), .irq(irq));
	gde_ahb_mem i_mem (.pclk(pclk), .presetn(presetn), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .slow(slow), .hrdata(hrdata), .hready(hready),
		.hresp(hresp));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task test_done();
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task give_up();
		failures++;
		$display("[ERR] %0t wait ran out", $time);
		test_done();
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
			give_up();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
	endtask
	task rd(input logic [11:0] a);
		logic e;
		apb(1'b0, a, 32'h0, e);
	endtask
	function automatic logic [11:0] chr(input int c, input logic [11:0] off);
		return GDE_CH_BASE + (c == 1 ? GDE_CH_STRIDE : 12'h000) + off;
	endfunction
	function automatic logic [31:0] ctl(input int cnt, input int bsz, input logic dinc);
		return 32'(cnt) | (32'(bsz) << GDE_BSZ_LSB) | (32'h2 << GDE_WID_LSB)
			| (32'h1 << GDE_SINC_BIT) | (32'(dinc) << GDE_DINC_BIT);
	endfunction
	task prog(input int c, input logic [31:0] s, d, l, ct, cf);
		wr(chr(c, GDE_CH_SRC), s);
		wr(chr(c, GDE_CH_DST), d);
		wr(chr(c, GDE_CH_LLI), l);
		wr(chr(c, GDE_CH_CTRL), ct);
		wr(chr(c, GDE_CH_CFG), cf);
	endtask
	task wait_stat(input logic [31:0] m);
		int n;
		for (n = 0; n < 200; n++) begin
			rd(GDE_INT_STAT);
			if ((q & m) !== 32'h0)
				break;
		end
		if (n == 200)
			give_up();
	endtask
	task m2m(input int c, input logic [31:0] s, d, l, input int cnt, bsz, input logic dinc);
		prog(c, s, d, l, ctl(cnt, bsz, dinc), 32'h1);
		wait_stat(32'h1 << c);
		chk(q, 32'h1 << c);
		rd(chr(c, GDE_CH_CFG));
		chk(q & 32'h1, 32'h0);
		wr(GDE_INT_CLR, 32'hF);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs();
		logic e;
		rd(GDE_INT_STAT);
		chk(q, GDE_RST_WORD);
		rd(chr(1, GDE_CH_CTRL));
		chk(q, GDE_RST_WORD);
		apb(1'b0, 12'h800, 32'h0, e);
		chk({q[30:0], e}, 32'h1);
		wr(GDE_INT_EN, 32'h5);
		rd(GDE_INT_EN);
		chk(q, 32'h5);
	endtask
	task t_burst_m2m();
		int i;
		for (i = 0; i < 64; i++)
			i_mem.mem[i] = 32'hA000_0000 + 32'(i);
		for (i = 16; i < 32; i++)
			i_mem.mem[i] = 32'h0;
		wr(GDE_INT_EN, 32'h1);
		prog(0, 32'h00, 32'h40, 32'h0, ctl(3, 2, 1'b1), 32'h1);
		wait_stat(32'h1);
		@(negedge pclk);
		chk(32'(irq), 32'h1);
		wr(GDE_INT_CLR, 32'hF);
		for (i = 0; i < 4; i++)
			chk(i_mem.mem[16 + i], i < 3 ? 32'hA000_0000 + 32'(i) : 32'h0);
		@(negedge pclk);
		chk(32'(irq), 32'h0);
	endtask
	task t_fixed_dst();
		m2m(1, 32'h00, 32'h60, 32'h0, 4, 0, 1'b0);
		chk(i_mem.mem[24], 32'hA000_0003);
		chk(i_mem.mem[25], 32'h0);
	endtask
	task t_chain();
		i_mem.mem[32] = 32'h08;
		i_mem.mem[33] = 32'h70;
		i_mem.mem[34] = 32'h0;
		i_mem.mem[35] = ctl(1, 0, 1'b1);
		slow <= 1'b1;
		m2m(0, 32'h00, 32'h68, 32'h80, 1, 0, 1'b1);
		slow <= 1'b0;
		chk(i_mem.mem[26], 32'hA000_0000);
		chk(i_mem.mem[28], 32'hA000_0002);
	endtask
	task t_priority();
		int n, busy;
		prog(1, 32'h14, 32'h50, 32'h0, ctl(1, 0, 1'b1), 32'h1 | (32'h1 << 1) | (32'h2 << 2));
		prog(0, 32'h10, 32'h58, 32'h0, ctl(1, 0, 1'b1), 32'h1 | (32'h1 << 1) | (32'h1 << 2));
		busy = 0;
		for (n = 0; n < 10; n++) begin
			@(negedge pclk);
			busy += (htrans !== GDE_HTRANS_IDLE);
		end
		chk(32'(busy), 32'h0);
		@(posedge pclk);
		per_sreq <= 4'h6;
		for (n = 0; n < 50 && htrans !== GDE_HTRANS_NSEQ; n++)
			@(negedge pclk);
		chk(haddr, 32'h10);
		for (n = 0; n < 300 && per_sreq !== 4'h0; n++) begin
			@(negedge pclk);
			if (per_clr !== 4'h0) begin
				@(posedge pclk);
				per_sreq <= per_sreq & ~per_clr;
			end
		end
		wait_stat(32'h2);
		chk(i_mem.mem[22], 32'hA000_0004);
		chk(i_mem.mem[20], 32'hA000_0005);
		wr(GDE_INT_CLR, 32'hF);
	endtask
	task t_burst_req();
		int n, pulses;
		prog(0, 32'h20, 32'h60, 32'h0, ctl(4, 1, 1'b1), 32'h1 | (32'h1 << 1));
		@(posedge pclk);
		per_breq <= 4'h1;
		pulses = 0;
		for (n = 0; n < 300; n++) begin
			@(negedge pclk);
			pulses += per_clr[0];
		end
		@(posedge pclk);
		per_breq <= 4'h0;
		chk(32'(pulses), 32'h2);
		wait_stat(32'h1);
		chk(i_mem.mem[24], 32'hA000_0008);
		chk(i_mem.mem[27], 32'hA000_000B);
		wr(GDE_INT_CLR, 32'hF);
	endtask
	task t_half();
		int n, hs;
		prog(0, 32'h00, 32'h70, 32'h0,
			32'h2 | (32'h1 << GDE_WID_LSB) | (32'h3 << GDE_SINC_BIT), 32'h1);
		hs = 0;
		for (n = 0; n < 40; n++) begin
			@(negedge pclk);
			hs += (htrans === GDE_HTRANS_NSEQ && hsize === 3'h1);
		end
		chk(32'(hs), 32'h4);
		wait_stat(32'h1);
		rd(chr(0, GDE_CH_SRC));
		chk(q, 32'h04);
		rd(chr(0, GDE_CH_DST));
		chk(q, 32'h74);
		chk(i_mem.mem[28], 32'hA000_0000);
		wr(GDE_INT_CLR, 32'hF);
	endtask
	task t_error();
		wr(GDE_INT_EN, 32'h3);
		prog(0, 32'hFC, 32'h40, 32'h0, ctl(1, 0, 1'b1), 32'h1);
		wait_stat(32'h4);
		chk(q, 32'h4);
		rd(GDE_INT_MASKED);
		chk(q, 32'h0);
		chk(32'(irq), 32'h0);
		wr(GDE_INT_EN, 32'hF);
		@(negedge pclk);
		chk(32'(irq), 32'h1);
		wr(GDE_INT_CLR, 32'h4);
		rd(GDE_INT_STAT);
		chk(q, 32'h0);
		chk(32'(irq), 32'h0);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		failures = 0;
		tests_run = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, slow} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		per_sreq = 4'h0;
		per_breq = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_burst_m2m();
		t_fixed_dst();
		t_chain();
		t_priority();
		t_burst_req();
		t_half();
		t_error();
		test_done();
	end
endmodule

// file: hw/gde_fifo.sv
// per-channel data buffer between source reads and destination writes
`timescale 1ns/1ps
module gde_fifo import gde_pkg::*; #(
	parameter int W = 32,
	parameter int D = GDE_FIFO_DEPTH
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         flush,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} gde_fifo_state_t;

	gde_fifo_state_t s;
	gde_fifo_state_t next_s;
	logic            push;
	logic            pop;

	assign in_ready  = s.cnt != (AW+1)'(D);
	assign out_valid = s.cnt != '0;
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
		end
		if (pop)
			next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) begin
			next_s.wp  = '0;
			next_s.rp  = '0;
			next_s.cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	a_fifo_depth: assert property (@(posedge pclk) disable iff (!presetn)
		s.cnt <= (AW+1)'(D)) else $error("fifo holds more than its depth"); // [RULE10]
endmodule

// file: hw/gde_pkg.sv
// constants and types shared by the general dma engine
package gde_pkg;
	localparam int GDE_NCH        = 2;
	localparam int GDE_NPER       = 4;
	localparam int GDE_FIFO_DEPTH = 4;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] GDE_INT_STAT   = 12'h000;
	localparam logic [11:0] GDE_INT_MASKED = 12'h004;
	localparam logic [11:0] GDE_INT_CLR    = 12'h008;
	localparam logic [11:0] GDE_INT_EN     = 12'h00C;
	localparam logic [11:0] GDE_CH_BASE    = 12'h100;
	localparam logic [11:0] GDE_CH_STRIDE  = 12'h020;
	localparam logic [11:0] GDE_CH_SRC     = 12'h000;
	localparam logic [11:0] GDE_CH_DST     = 12'h004;
	localparam logic [11:0] GDE_CH_LLI     = 12'h008;
	localparam logic [11:0] GDE_CH_CTRL    = 12'h00C;
	localparam logic [11:0] GDE_CH_CFG     = 12'h010;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int GDE_CNT_W    = 12;
	localparam int GDE_BSZ_LSB  = 12;
	localparam int GDE_WID_LSB  = 14;
	localparam int GDE_SINC_BIT = 16;
	localparam int GDE_DINC_BIT = 17;
	localparam int GDE_EN_BIT   = 0;
	localparam int GDE_SPER_BIT = 1;
	localparam int GDE_SSEL_LSB = 2;
	localparam int GDE_DPER_BIT = 4;
	localparam int GDE_DSEL_LSB = 5;

	// peripheral request line numbers
	localparam int GDE_PER_CARD = 0;
	localparam int GDE_PER_SSP0 = 1;
	localparam int GDE_PER_SSP1 = 2;
	localparam int GDE_PER_I2S  = 3;

	// ----------------------------------------------------------------
	// reset values and bus codes
	// ----------------------------------------------------------------
	localparam logic [31:0] GDE_RST_WORD    = 32'h0000_0000;
	localparam logic [7:0]  GDE_RST_CFG     = 8'h00;
	localparam logic [1:0]  GDE_HTRANS_IDLE = 2'h0;
	localparam logic [1:0]  GDE_HTRANS_NSEQ = 2'h2;
	localparam logic [2:0]  GDE_HSIZE_WORD  = 3'h2;
	localparam logic [31:0] GDE_WORD_STEP   = 32'h0000_0004;

	typedef enum logic [2:0] {
		GDE_IDLE, GDE_LL_A, GDE_LL_D, GDE_RD_A, GDE_RD_D, GDE_WR_A, GDE_WR_D
	} gde_state_t;
endpackage

// file: hw/gde_top.sv
// two-channel general dma engine with apb registers and ahb-lite master
//
// Functional notes
// RULE1: any mix of memory and peripheral ends
// RULE2: each channel moves data one way only
// RULE3: channel 0 wins over channel 1
// RULE4: single and burst requests both serviced
// RULE5: software sets words per burst request
// RULE6: linked descriptors chain non-contiguous regions
// RULE7: software programs channels before they start
// RULE8: one 32-bit master, moves only on request
// RULE9: source and destination increment or stay fixed
// RULE10: four-word buffer in every channel
// RULE11: byte, halfword and word transfers
// RULE12: interrupt on completion and on error
// RULE13: error and count interrupts are maskable
// RULE14: raw status readable regardless of mask
// RULE15: serves sram, card, serial and audio ports
// RULE16: count exhausted, no link: flag, stop
`timescale 1ns/1ps
module gde_top import gde_pkg::*; #(
	parameter int NCH  = GDE_NCH,
	parameter int NPER = GDE_NPER
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	output logic [31:0]          haddr,
	output logic [1:0]           htrans,
	output logic                 hwrite,
	output logic [2:0]           hsize,
	output logic [31:0]          hwdata,
	input  wire logic [31:0]     hrdata,
	input  wire logic            hready,
	input  wire logic            hresp,
	input  wire logic [NPER-1:0] per_sreq,
	input  wire logic [NPER-1:0] per_breq,
	output logic [NPER-1:0]      per_clr,
	output logic                 irq
);
	localparam int CW = $clog2(NCH);
	localparam int PW = $clog2(NPER);

	typedef struct packed {
		logic [NCH-1:0][31:0]   src;
		logic [NCH-1:0][31:0]   dst;
		logic [NCH-1:0][31:0]   lli;
		logic [NCH-1:0][31:0]   ctrl;
		logic [NCH-1:0][7:0]    cfg;
		logic [2*NCH-1:0]       stat;
		logic [2*NCH-1:0]       ien;
		gde_state_t             st;
		logic [CW-1:0]          ch;
		logic [2:0]             n;
		logic [2:0]             k;
		logic [31:0]            haddr;
		logic [31:0]            hwdata;
		logic [1:0]             htrans;
		logic                   hwrite;
		logic [2:0]             hsize;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic [NPER-1:0]        per_clr;
		logic                   irq;
	} gde_top_state_t;

	gde_top_state_t s;
	gde_top_state_t next_s;

	logic [NCH-1:0]  rdy;
	logic [NCH-1:0]  f_in_valid;
	logic [NCH-1:0]  f_in_ready;
	logic [NCH-1:0]  f_out_valid;
	logic [NCH-1:0]  f_out_ready;
	logic [NCH-1:0]  f_flush;
	logic [31:0]     f_out_data [NCH];

	// ----------------------------------------------------------------
	// per-channel buffers and request readiness
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		logic          sp;
		logic          dp;
		logic [PW-1:0] ss;
		logic [PW-1:0] ds;
		assign sp = s.cfg[g][GDE_SPER_BIT];
		assign dp = s.cfg[g][GDE_DPER_BIT];
		assign ss = s.cfg[g][GDE_SSEL_LSB +: PW];
		assign ds = s.cfg[g][GDE_DSEL_LSB +: PW];
		// memory ends never wait, peripheral ends wait for a request
		assign rdy[g] = (!sp | per_sreq[ss] | per_breq[ss])
		              & (!dp | per_sreq[ds] | per_breq[ds]); // [RULE1] [RULE4] [RULE15]

		gde_fifo #(.W(32), .D(GDE_FIFO_DEPTH)) u_fifo ( // [RULE10]
			.pclk      (pclk),
			.presetn   (presetn),
			.flush     (f_flush[g]),
			.in_valid  (f_in_valid[g]),
			.in_data   (hrdata),
			.in_ready  (f_in_ready[g]),
			.out_valid (f_out_valid[g]),
			.out_data  (f_out_data[g]),
			.out_ready (f_out_ready[g])
		);
	end

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [11:0]          off;
		logic [11:0]          roff;
		logic [11:0]          cidx;
		logic [31:0]          rd;
		logic                 hit;
		logic [2*NCH-1:0]     clr;
		logic [2*NCH-1:0]     set;
		logic                 found;
		logic [CW-1:0]        pc;
		logic [1:0]           wid;
		logic [31:0]          inc;
		logic [2:0]           bw;
		logic                 pq;
		logic [GDE_CNT_W-1:0] cnt;
		logic                 fail;
		off    = paddr - GDE_CH_BASE;
		roff   = off % GDE_CH_STRIDE;
		cidx   = off / GDE_CH_STRIDE;
		rd     = '0;
		hit    = 1'b1;
		clr    = '0;
		set    = '0;
		found  = 1'b0;
		pc     = '0;
		wid    = s.ctrl[s.ch][GDE_WID_LSB +: 2];
		inc    = 32'h0000_0001 << wid;
		bw     = 3'h1;
		pq     = 1'b1;
		cnt    = s.ctrl[s.ch][GDE_CNT_W-1:0];
		fail   = 1'b0;
		next_s = s;
		next_s.pready  = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.per_clr = '0;
		f_in_valid  = '0;
		f_out_ready = '0;
		f_flush     = '0;

		// register port: no wait states, answer registered
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			if (paddr == GDE_INT_STAT)
				rd = 32'(s.stat); // [RULE14]
			else if (paddr == GDE_INT_MASKED)
				rd = 32'(s.stat & s.ien);
			else if (paddr == GDE_INT_EN)
				rd = 32'(s.ien);
			else if (paddr == GDE_INT_CLR)
				rd = '0;
			else if (paddr >= GDE_CH_BASE && cidx < 12'(NCH)) begin
				case (roff)
				GDE_CH_SRC:  rd = s.src[cidx[CW-1:0]];
				GDE_CH_DST:  rd = s.dst[cidx[CW-1:0]];
				GDE_CH_LLI:  rd = s.lli[cidx[CW-1:0]];
				GDE_CH_CTRL: rd = s.ctrl[cidx[CW-1:0]];
				GDE_CH_CFG:  rd = 32'(s.cfg[cidx[CW-1:0]]);
				default:     hit = 1'b0;
				endcase
			end else
				hit = 1'b0;
			next_s.prdata  = rd;
			next_s.pslverr = !hit;
		end
		if (psel && penable && s.pready && pwrite && !s.pslverr) begin // [RULE7]
			if (paddr == GDE_INT_CLR)
				clr = pwdata[2*NCH-1:0];
			else if (paddr == GDE_INT_EN)
				next_s.ien = pwdata[2*NCH-1:0]; // [RULE13]
			else if (paddr >= GDE_CH_BASE && cidx < 12'(NCH)) begin
				case (roff)
				GDE_CH_SRC:  next_s.src[cidx[CW-1:0]] = pwdata;
				GDE_CH_DST:  next_s.dst[cidx[CW-1:0]] = pwdata;
				GDE_CH_LLI:  next_s.lli[cidx[CW-1:0]] = pwdata;
				GDE_CH_CTRL: next_s.ctrl[cidx[CW-1:0]] = pwdata;
				GDE_CH_CFG:  next_s.cfg[cidx[CW-1:0]] = pwdata[7:0];
				default:     ;
				endcase
			end
		end

		// transfer engine
		case (s.st)
		GDE_IDLE: begin
			for (int c = NCH - 1; c >= 0; c--) begin
				if (s.cfg[c][GDE_EN_BIT] &&
				    (s.ctrl[c][GDE_CNT_W-1:0] == '0 || rdy[c])) begin // [RULE3] [RULE8]
					found = 1'b1;
					pc = CW'(c);
				end
			end
			if (found) begin
				next_s.ch = pc;
				cnt = s.ctrl[pc][GDE_CNT_W-1:0];
				next_s.k = '0;
				next_s.htrans = GDE_HTRANS_NSEQ;
				next_s.hwrite = 1'b0;
				if (cnt == '0) begin
					if (s.lli[pc] != '0) begin
						next_s.st = GDE_LL_A; // [RULE6]
						next_s.haddr = s.lli[pc];
						next_s.hsize = GDE_HSIZE_WORD;
					end else begin
						set[pc] = 1'b1; // [RULE16] [RULE12]
						next_s.cfg[pc][GDE_EN_BIT] = 1'b0;
						next_s.htrans = GDE_HTRANS_IDLE;
					end
				end else begin
					case (s.ctrl[pc][GDE_BSZ_LSB +: 2])
					2'h0:    bw = 3'h1;
					2'h1:    bw = 3'h2;
					default: bw = 3'h4;
					endcase
					if (s.cfg[pc][GDE_SPER_BIT])
						pq = per_breq[s.cfg[pc][GDE_SSEL_LSB +: PW]];
					else if (s.cfg[pc][GDE_DPER_BIT])
						pq = per_breq[s.cfg[pc][GDE_DSEL_LSB +: PW]];
					next_s.n = pq ? bw : 3'h1; // [RULE5] [RULE4]
					if (cnt < GDE_CNT_W'(next_s.n))
						next_s.n = cnt[2:0];
					next_s.st = GDE_RD_A;
					next_s.haddr = s.src[pc];
					next_s.hsize = {1'b0, s.ctrl[pc][GDE_WID_LSB +: 2]}; // [RULE11]
				end
			end
		end
		GDE_LL_A, GDE_RD_A: begin
			if (hready) begin
				next_s.htrans = GDE_HTRANS_IDLE;
				next_s.st = (s.st == GDE_LL_A) ? GDE_LL_D : GDE_RD_D;
			end
		end
		GDE_LL_D: begin
			if (hready) begin
				fail = hresp;
				if (!hresp) begin
					case (s.k[1:0])
					2'h0:    next_s.src[s.ch]  = hrdata;
					2'h1:    next_s.dst[s.ch]  = hrdata;
					2'h2:    next_s.lli[s.ch]  = hrdata; // [RULE6]
					default: next_s.ctrl[s.ch] = hrdata;
					endcase
					if (s.k == 3'h3)
						next_s.st = GDE_IDLE;
					else begin
						next_s.st = GDE_LL_A;
						next_s.haddr = s.haddr + GDE_WORD_STEP;
						next_s.htrans = GDE_HTRANS_NSEQ;
						next_s.k = s.k + 3'h1;
					end
				end
			end
		end
		GDE_RD_D: begin
			if (hready) begin
				fail = hresp;
				if (!hresp) begin
					f_in_valid[s.ch] = 1'b1;
					if (s.ctrl[s.ch][GDE_SINC_BIT])
						next_s.src[s.ch] = s.src[s.ch] + inc; // [RULE9]
					next_s.htrans = GDE_HTRANS_NSEQ;
					if (s.k + 3'h1 == s.n) begin
						next_s.st = GDE_WR_A; // [RULE2]
						next_s.k = '0;
						next_s.haddr = s.dst[s.ch];
						next_s.hwrite = 1'b1;
					end else begin
						next_s.st = GDE_RD_A;
						next_s.k = s.k + 3'h1;
						next_s.haddr = next_s.src[s.ch];
					end
				end
			end
		end
		GDE_WR_A: begin
			if (hready) begin
				next_s.htrans = GDE_HTRANS_IDLE;
				next_s.hwdata = f_out_data[s.ch];
				f_out_ready[s.ch] = 1'b1;
				next_s.st = GDE_WR_D;
			end
		end
		GDE_WR_D: begin
			if (hready) begin
				fail = hresp;
				if (!hresp) begin
					if (s.ctrl[s.ch][GDE_DINC_BIT])
						next_s.dst[s.ch] = s.dst[s.ch] + inc; // [RULE9]
					next_s.ctrl[s.ch][GDE_CNT_W-1:0] = cnt - 1'b1;
					if (s.k + 3'h1 == s.n) begin
						next_s.st = GDE_IDLE;
						next_s.hwrite = 1'b0;
						if (s.cfg[s.ch][GDE_SPER_BIT])
							next_s.per_clr[s.cfg[s.ch][GDE_SSEL_LSB +: PW]] = 1'b1;
						if (s.cfg[s.ch][GDE_DPER_BIT])
							next_s.per_clr[s.cfg[s.ch][GDE_DSEL_LSB +: PW]] = 1'b1;
					end else begin
						next_s.st = GDE_WR_A;
						next_s.k = s.k + 3'h1;
						next_s.haddr = next_s.dst[s.ch];
						next_s.htrans = GDE_HTRANS_NSEQ;
					end
				end
			end
		end
		default: next_s.st = GDE_IDLE;
		endcase

		// bus error: flag, disable channel, drop buffered data
		if (fail) begin
			set[NCH + int'(s.ch)] = 1'b1; // [RULE12]
			next_s.cfg[s.ch][GDE_EN_BIT] = 1'b0;
			next_s.st = GDE_IDLE;
			next_s.htrans = GDE_HTRANS_IDLE;
			next_s.hwrite = 1'b0;
			f_flush[s.ch] = 1'b1;
		end

		// set wins over a clear in the same cycle
		next_s.stat = (s.stat & ~clr) | set;
		next_s.irq = |(next_s.stat & next_s.ien); // [RULE13]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= GDE_IDLE;
		end else
			s <= next_s;
	end

	assign prdata  = s.prdata;
	assign pready  = s.pready;
	assign pslverr = s.pslverr;
	assign haddr   = s.haddr;
	assign htrans  = s.htrans;
	assign hwrite  = s.hwrite;
	assign hsize   = s.hsize;
	assign hwdata  = s.hwdata;
	assign per_clr = s.per_clr;
	assign irq     = s.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_prio_ch_zero: assert property (s.st == GDE_IDLE && (&s.cfg[0][0] && &s.cfg[1][0])
		&& s.ctrl[0][GDE_CNT_W-1:0] != '0 && &rdy |=> s.ch == '0) // [RULE3]
		else $error("channel 1 served before channel 0");
	a_idle_no_req: assert property (s.st == GDE_IDLE && (rdy & {s.cfg[1][0], s.cfg[0][0]}) == '0
		&& s.ctrl[0][GDE_CNT_W-1:0] != '0 && s.ctrl[1][GDE_CNT_W-1:0] != '0
		|=> htrans == GDE_HTRANS_IDLE) // [RULE8]
		else $error("bus started without a request");
	a_src_fixed: assert property (s.st == GDE_RD_D && hready && !hresp
		&& !s.ctrl[s.ch][GDE_SINC_BIT] |=> $stable(s.src[s.ch])) // [RULE9]
		else $error("fixed source address moved");
	a_hsize_width: assert property (htrans == GDE_HTRANS_NSEQ && s.st != GDE_LL_A
		|-> hsize == {1'b0, s.ctrl[s.ch][GDE_WID_LSB +: 2]}) // [RULE11]
		else $error("transfer size differs from programmed width");
	a_err_flag: assert property ((s.st == GDE_RD_D || s.st == GDE_WR_D) && hready && hresp
		|=> s.stat[NCH + int'($past(s.ch))] && s.st == GDE_IDLE) // [RULE12]
		else $error("bus error not flagged");
	a_irq_masked: assert property ((s.stat & s.ien) == '0 |-> !irq) // [RULE13]
		else $error("masked request reached interrupt output");
	a_raw_read: assert property (psel && !penable && paddr == GDE_INT_STAT
		|=> pready && prdata == 32'($past(s.stat))) // [RULE14]
		else $error("raw status read wrong");
	a_tc_stop: assert property ($rose(s.stat[0]) |-> !s.cfg[0][GDE_EN_BIT]
		##1 htrans == GDE_HTRANS_IDLE || s.ch != '0) // [RULE16]
		else $error("channel kept running after terminal count");
	a_chunk_len: assert property (s.st == GDE_WR_A |-> s.k < s.n && s.n <= 3'h4) // [RULE5]
		else $error("burst chunk exceeds programmed length");
	a_write_only: assert property (htrans == GDE_HTRANS_NSEQ && hwrite |-> s.st == GDE_WR_A) // [RULE2]
		else $error("write issued outside destination phase");
endmodule
